// *** sdc_cmd_core.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sdc_map.svh"
module sdc_cmd_core #(
  parameter int unsigned MS_TICKS = `SDC_MS_NS / `SDC_CLK_PERIOD_NS // cycles per ms
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic link_reset_req,
  input wire logic spin_ready,
  input wire logic op_done,
  output logic op_start,
  output logic [7:0] op_code,
  output logic spin_up_req,
  output logic init_signal,
  output logic host_intrq,
  output logic irq
);
  // pin synchronisers
  logic lr_s1_q, lr_s2_q, lr_s3_q; // link reset request stages and edge history
  logic sp_s1_q, sp_s2_q; // spindle at speed stages

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      {lr_s1_q, lr_s2_q, lr_s3_q} <= 3'h0;
      {sp_s1_q, sp_s2_q} <= 2'h0;
    end else if (ce) begin
      lr_s1_q <= link_reset_req;
      lr_s2_q <= lr_s1_q;
      lr_s3_q <= lr_s2_q;
      sp_s1_q <= spin_ready;
      sp_s2_q <= sp_s1_q;
    end
  end

  wire logic lr_edge = ce & lr_s2_q & ~lr_s3_q; // new link reset request

  // bus slave: one wait cycle, effects at the edge that ends the access
  logic ack_q; // second cycle of an access
  wire logic bus_req = avs_read | avs_write;
  wire logic take = ce & bus_req & ~ack_q; // first edge: read data latched
  wire logic fin = ce & bus_req & ack_q; // final edge: effects
  wire logic wr_fin = fin & avs_write;
  wire logic rd_fin = fin & avs_read;
  // a frozen clock enable keeps the master waiting, so no access ends unseen
  assign avs_waitrequest = bus_req & (~ack_q | ~ce);

  always_ff @(posedge clock) begin
    if (!rst_b) ack_q <= 1'b0;
    else if (ce) ack_q <= take;
  end

  // address decode
  wire logic hit_ctrl = (avs_address == `SDC_OFF_CTRL);
  wire logic hit_cmd = (avs_address == `SDC_OFF_CMD);
  wire logic hit_tlim = (avs_address == `SDC_OFF_TLIM);
  wire logic hit_dc = (avs_address == `SDC_OFF_DEVCTL);
  wire logic hit_stat = (avs_address == `SDC_OFF_STATUS);
  wire logic hit_alt = (avs_address == `SDC_OFF_ALTSTAT);
  wire logic hit_res = (avs_address == `SDC_OFF_RESULT);
  wire logic hit_ist = (avs_address == `SDC_OFF_IRQ_STAT);
  wire logic hit_msk = (avs_address == `SDC_OFF_IRQ_MASK);
  wire logic hit_cause = (avs_address == `SDC_OFF_CAUSE);

  // software state
  logic epc_q; // extended power conditions enabled
  logic lock_q; // security locked
  logic stby_q; // standby, spindle stopped
  logic [16:0] tlim_q; // requested limit and recovery flag
  logic high_order_byte_select_q, soft_reset_bit_q, nien_q; // device control bits
  logic [3:0] mask_q; // interrupt mask
  logic [3:0] irq_q; // sticky interrupt status
  logic [1:0] cause_q; // cause of the last power-on or link reset

  // command state
  sdc_pkg::sdc_state_t st_q, st_d; // sequencer
  logic [7:0] sec_q; // sector count answer
  logic [7:0] err_q; // error byte
  logic errf_q; // status error flag
  logic [15:0] lim_q; // limit in force, ms
  logic lim_en_q; // a limit applies to this command
  logic pend_q; // interrupt pending toward the host
  logic lr_pend_q; // link reset awaiting its answer
  logic [15:0] por_ms, cmd_ms; // elapsed times

  // command decode at issue
  wire logic [7:0] wcode = avs_writedata[7:0];
  wire logic [15:0] tlim_ms = tlim_q[15:0];
  wire logic erc = tlim_q[`SDC_TLIM_ERC];
  wire logic is_chk = (wcode == `SDC_CMD_CHK_PWR);
  wire logic is_dl = (wcode == `SDC_CMD_DL) | (wcode == `SDC_CMD_DL_DMA);
  wire logic is_strm = (wcode == `SDC_CMD_RD_STRM) | (wcode == `SDC_CMD_WR_STRM);
  wire logic dl_locked = is_dl & lock_q;
  wire logic erc_short = erc & (tlim_ms < `SDC_ERC_MIN_MS);
  wire logic abort_go = dl_locked | erc_short;
  wire logic busy = (st_q != sdc_pkg::SDC_IDLE) | soft_reset_bit_q;
  wire logic cmd_go = wr_fin & hit_cmd & ~busy & ~lr_edge;
  wire logic strm_low = is_strm & (tlim_ms < `SDC_COMPLETION_LIMIT_FLOOR_MS);
  wire logic [15:0] lim_eff = strm_low ? `SDC_COMPLETION_LIMIT_FLOOR_MS : tlim_ms;
  wire logic [7:0] pm_code = stby_q ? `SDC_PM_STBY :
                             (epc_q ? `SDC_PM_IDLE_STD : `SDC_PM_IDLE_ALL);

  // completion events; the limit is only checked once executing
  wire logic in_exec = (st_q == sdc_pkg::SDC_EXEC);
  wire logic live = ce & ~soft_reset_bit_q & ~lr_edge;
  wire logic tmo_hit = live & in_exec & ~op_done & lim_en_q & (cmd_ms >= lim_q);
  wire logic done_ok = live & ((cmd_go & is_chk & ~abort_go) | (in_exec & op_done));
  wire logic done_abt = (cmd_go & abort_go) | tmo_hit;
  wire logic cmp_ev = done_ok | done_abt;
  wire logic cblk_wr = wr_fin & (hit_cmd | hit_tlim); // command-block write

  // next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      sdc_pkg::SDC_IDLE: begin
        if (cmd_go && !abort_go && !is_chk) begin
          st_d = stby_q ? sdc_pkg::SDC_SPIN : sdc_pkg::SDC_EXEC;
        end
      end
      sdc_pkg::SDC_SPIN: begin
        // no limit check here: completion waits for speed
        if (sp_s2_q) st_d = sdc_pkg::SDC_EXEC;
      end
      sdc_pkg::SDC_EXEC: begin
        if (op_done || tmo_hit) st_d = sdc_pkg::SDC_IDLE;
      end
      default: st_d = sdc_pkg::SDC_IDLE;
    endcase
    if (soft_reset_bit_q || lr_edge) st_d = sdc_pkg::SDC_IDLE; // both resets drop the command
  end

  // sequencer and start pulse
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      st_q <= sdc_pkg::SDC_IDLE;
      op_start <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      op_start <= (st_d == sdc_pkg::SDC_EXEC) & ~in_exec;
    end
  end

  // command results, set at issue and on a timeout
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      op_code <= 8'h00;
      sec_q <= 8'h00;
      err_q <= 8'h00;
      errf_q <= 1'b0;
      lim_q <= 16'h0;
      lim_en_q <= 1'b0;
    end else if (cmd_go) begin
      op_code <= wcode;
      sec_q <= is_chk ? pm_code : sec_q;
      err_q <= abort_go ? (8'h01 << `SDC_ER_ABRT) : 8'h00;
      errf_q <= abort_go;
      lim_q <= lim_eff;
      lim_en_q <= is_strm | erc;
    end else if (tmo_hit) begin
      err_q[`SDC_ER_ABRT] <= 1'b1;
      errf_q <= 1'b1;
    end
  end

  // software registers; writing any command-block register drops the high byte select
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      {epc_q, lock_q, stby_q} <= 3'h0;
      tlim_q <= `SDC_TLIM_RST;
      {high_order_byte_select_q, soft_reset_bit_q, nien_q} <= 3'h0;
      mask_q <= `SDC_MASK_RST;
    end else if (ce) begin
      if (wr_fin && hit_ctrl) begin
        epc_q <= avs_writedata[`SDC_CTRL_EPC];
        lock_q <= avs_writedata[`SDC_CTRL_LOCK];
        stby_q <= avs_writedata[`SDC_CTRL_STBY];
      end
      if (wr_fin && hit_tlim) tlim_q <= avs_writedata[16:0];
      if (wr_fin && hit_msk) mask_q <= avs_writedata[3:0];
      if (wr_fin && hit_dc) begin
        high_order_byte_select_q <= avs_writedata[`SDC_DC_HIGH_ORDER_BYTE_SELECT];
        soft_reset_bit_q <= avs_writedata[`SDC_DC_SOFT_RESET_BIT];
        nien_q <= avs_writedata[`SDC_DC_NIEN];
      end
      if (cblk_wr) high_order_byte_select_q <= 1'b0;
      if (st_q == sdc_pkg::SDC_SPIN && sp_s2_q) stby_q <= 1'b0; // spindle at speed
    end
  end

  // pending interrupt: a primary status read acknowledges, alternate does not
  wire logic pend_ack = rd_fin & hit_stat;
  always_ff @(posedge clock) begin
    if (!rst_b) pend_q <= 1'b0;
    else if (ce) pend_q <= cmp_ev | (pend_q & ~pend_ack & ~soft_reset_bit_q & ~lr_edge);
  end
  assign host_intrq = pend_q & ~nien_q;

  // sticky interrupt status, write one to clear, events win
  logic [3:0] irq_ev;
  logic [3:0] irq_clr;
  always_comb begin
    irq_ev = 4'h0;
    irq_ev[`SDC_IRQ_DONE] = done_ok;
    irq_ev[`SDC_IRQ_ABORT] = done_abt;
    irq_ev[`SDC_IRQ_LRST] = lr_edge;
    irq_ev[`SDC_IRQ_TMO] = tmo_hit;
    irq_clr = (wr_fin && hit_ist) ? avs_writedata[3:0] : 4'h0;
  end
  always_ff @(posedge clock) begin
    if (!rst_b) irq_q <= 4'h0;
    else if (ce) irq_q <= irq_ev | (irq_q & ~irq_clr);
  end
  assign irq = |(irq_q & mask_q);

  // link reset: answer once the power-on quiet interval is over
  wire logic por_ok = (por_ms >= `SDC_POR_QUIET_MS);
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      lr_pend_q <= 1'b0;
      init_signal <= 1'b0;
      cause_q <= `SDC_CAUSE_POR;
    end else if (ce) begin
      init_signal <= lr_pend_q & por_ok;
      lr_pend_q <= lr_edge | (lr_pend_q & ~por_ok);
      if (lr_edge) cause_q <= `SDC_CAUSE_LINK;
    end
  end

  assign spin_up_req = (st_q == sdc_pkg::SDC_SPIN);

  // time since power-on, and since command issue
  sdc_ms_timer #(.MS_TICKS(MS_TICKS)) u_por_timer (
    .clock(clock), .rst_b(rst_b), .ce(ce), .clear(1'b0), .elapsed_ms(por_ms)
  );
  sdc_ms_timer #(.MS_TICKS(MS_TICKS)) u_cmd_timer (
    .clock(clock), .rst_b(rst_b), .ce(ce), .clear(cmd_go), .elapsed_ms(cmd_ms)
  );

  // status byte, shared by both status copies
  logic [7:0] stat_byte;
  logic [7:0] dc_byte;
  always_comb begin
    stat_byte = 8'h00;
    stat_byte[`SDC_ST_BUSY_FLAG] = busy;
    stat_byte[`SDC_ST_DRDY] = ~busy;
    stat_byte[`SDC_ST_DSC] = 1'b1;
    stat_byte[`SDC_ST_ERR] = errf_q;
    dc_byte = 8'h00;
    dc_byte[`SDC_DC_HIGH_ORDER_BYTE_SELECT] = high_order_byte_select_q;
    dc_byte[`SDC_DC_ONE] = 1'b1;
    dc_byte[`SDC_DC_SOFT_RESET_BIT] = soft_reset_bit_q;
    dc_byte[`SDC_DC_NIEN] = nien_q;
  end

  // read selection; unmapped reads return zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    if (hit_ctrl) rd_mux = {29'h0, stby_q, lock_q, epc_q};
    else if (hit_cmd) rd_mux = {24'h0, op_code};
    else if (hit_tlim) rd_mux = {15'h0, tlim_q};
    else if (hit_dc) rd_mux = {24'h0, dc_byte};
    else if (hit_stat || hit_alt) rd_mux = {24'h0, stat_byte};
    else if (hit_res) rd_mux = {16'h0, err_q, sec_q};
    else if (hit_ist) rd_mux = {28'h0, irq_q};
    else if (hit_msk) rd_mux = {28'h0, mask_q};
    else if (hit_cause) rd_mux = {30'h0, cause_q};
  end

  always_ff @(posedge clock) begin
    if (!rst_b) avs_readdata <= 32'h0;
    else if (take && avs_read) avs_readdata <= rd_mux;
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  AST_IDLE_PWR_CODE: assert property (
    cmd_go && is_chk && !abort_go && !stby_q && !epc_q |=> sec_q == 8'hFF && !busy
  ) else $error("idle power query did not answer FFh");
  AST_DL_LOCKED: assert property (
    cmd_go && dl_locked |=> err_q[`SDC_ER_ABRT] && errf_q && st_q == sdc_pkg::SDC_IDLE
  ) else $error("download while locked not aborted");
  AST_INIT_QUIET: assert property (
    $rose(init_signal) |-> $past(por_ms) >= `SDC_POR_QUIET_MS
  ) else $error("link reset answered inside power-on quiet interval");
  AST_INIT_PROMPT: assert property (
    ce && lr_pend_q && por_ok |=> init_signal ##1 (!init_signal || lr_pend_q)
  ) else $error("link reset answer late or repeated");
  AST_COMPL_LIMIT_FLOOR: assert property (
    cmd_go && is_strm && !abort_go |=> lim_q >= `SDC_COMPLETION_LIMIT_FLOOR_MS && lim_en_q
  ) else $error("streaming limit below floor");
  AST_SPIN_HOLD: assert property (
    st_q == sdc_pkg::SDC_SPIN && !sp_s2_q && !soft_reset_bit_q && !lr_edge |=>
      st_q == sdc_pkg::SDC_SPIN
  ) else $error("command left spin-up wait early");
  AST_ERC_MIN: assert property (
    cmd_go && erc && tlim_ms < `SDC_ERC_MIN_MS |-> done_abt ##1 irq_q[`SDC_IRQ_ABORT]
  ) else $error("short recovery limit not aborted");
  AST_ERC_WAIT: assert property (
    ce && st_q == sdc_pkg::SDC_SPIN && sp_s2_q && !soft_reset_bit_q && !lr_edge |=>
      in_exec
  ) else $error("spun-up command did not go on to execute");
  AST_LINK_NOT_POR: assert property (
    lr_edge && !wr_fin |=> cause_q == `SDC_CAUSE_LINK && mask_q == $past(mask_q) &&
      tlim_q == $past(tlim_q) && lr_pend_q
  ) else $error("link reset handled like power-on");
  AST_STAT_ACK: assert property (
    pend_ack && !cmp_ev |=> !pend_q && !host_intrq
  ) else $error("status read did not clear pending interrupt");
  AST_ALT_KEEP: assert property (
    rd_fin && hit_alt && pend_q && !soft_reset_bit_q && !lr_edge |=> pend_q
  ) else $error("alternate status read cleared interrupt");
  AST_HIGH_BYTE_CLR: assert property (
    cblk_wr |=> !high_order_byte_select_q
  ) else $error("command-block write left high byte select set");
endmodule : sdc_cmd_core
`default_nettype wire

// *** sdc_map.svh ***
`ifndef SDC_MAP_SVH
`define SDC_MAP_SVH
// clock and time base
`define SDC_CLK_PERIOD_NS 10
`define SDC_MS_NS 1000000
// quiet interval after power-on, least completion limit, least recovery limit (ms)
`define SDC_POR_QUIET_MS 16'h01F4
`define SDC_COMPLETION_LIMIT_FLOOR_MS 16'h0032
`define SDC_ERC_MIN_MS 16'h1964
// register byte offsets
`define SDC_OFF_CTRL 8'h00
`define SDC_OFF_CMD 8'h04
`define SDC_OFF_TLIM 8'h08
`define SDC_OFF_DEVCTL 8'h0C
`define SDC_OFF_STATUS 8'h10
`define SDC_OFF_ALTSTAT 8'h14
`define SDC_OFF_RESULT 8'h18
`define SDC_OFF_IRQ_STAT 8'h1C
`define SDC_OFF_IRQ_MASK 8'h20
`define SDC_OFF_CAUSE 8'h24
// control register fields
`define SDC_CTRL_EPC 0
`define SDC_CTRL_LOCK 1
`define SDC_CTRL_STBY 2
// time limit register: limit in ms in [15:0], recovery-limit flag
`define SDC_TLIM_ERC 16
// device control fields
`define SDC_DC_HIGH_ORDER_BYTE_SELECT 7
`define SDC_DC_ONE 3
`define SDC_DC_SOFT_RESET_BIT 2
`define SDC_DC_NIEN 1
// status byte fields
`define SDC_ST_BUSY_FLAG 7
`define SDC_ST_DRDY 6
`define SDC_ST_DSC 4
`define SDC_ST_ERR 0
// error byte field
`define SDC_ER_ABRT 2
// interrupt status bits
`define SDC_IRQ_DONE 0
`define SDC_IRQ_ABORT 1
`define SDC_IRQ_LRST 2
`define SDC_IRQ_TMO 3
// reset cause codes
`define SDC_CAUSE_POR 2'h2
`define SDC_CAUSE_LINK 2'h1
// power mode answers
`define SDC_PM_STBY 8'h00
`define SDC_PM_IDLE_STD 8'h80
`define SDC_PM_IDLE_ALL 8'hFF
// command codes
`define SDC_CMD_CHK_PWR 8'hE5
`define SDC_CMD_DL 8'h92
`define SDC_CMD_DL_DMA 8'h93
`define SDC_CMD_RD_STRM 8'h2A
`define SDC_CMD_WR_STRM 8'h3A
// reset values
`define SDC_TLIM_RST 17'h00000
`define SDC_MASK_RST 4'h0
`endif

// *** sdc_pkg.sv ***
package sdc_pkg;
  // command sequencer states, one-hot
  typedef enum logic [2:0] {
    SDC_IDLE = 3'b001,
    SDC_SPIN = 3'b010,
    SDC_EXEC = 3'b100
  } sdc_state_t;
endpackage : sdc_pkg

// *** sdc_ms_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
// millisecond counter, saturating, restarted by clear
module sdc_ms_timer #(
  parameter int unsigned MS_TICKS = 100000 // cycles per millisecond
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic clear,
  output logic [15:0] elapsed_ms
);
  logic [31:0] tick_q; // cycles inside the current millisecond
  wire logic ms_wrap = (tick_q == MS_TICKS - 32'h1);

  // count cycles, then whole milliseconds; stop at the top value
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tick_q <= 32'h0;
      elapsed_ms <= 16'h0;
    end else if (ce) begin
      if (clear) begin
        tick_q <= 32'h0;
        elapsed_ms <= 16'h0;
      end else if (ms_wrap) begin
        tick_q <= 32'h0;
        if (elapsed_ms != 16'hFFFF) elapsed_ms <= elapsed_ms + 16'h1;
      end else begin
        tick_q <= tick_q + 32'h1;
      end
    end
  end
endmodule : sdc_ms_timer
`default_nettype wire

// *** sdc_far_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// behavioural backend and spindle on the far side of the command core
module sdc_far_model (
  input wire logic clock,
  input wire logic spin_up_req,
  input wire logic op_start,
  input wire logic [15:0] spin_dly,
  input wire logic [15:0] done_dly,
  output logic spin_ready,
  output logic op_done
);
  logic [15:0] spin_cnt = 16'h0000; // cycles since spin-up was asked for
  logic [15:0] done_cnt = 16'h0000; // cycles since the last start
  logic run = 1'b0; // an operation has been started; set by the first start, never cleared
  initial spin_ready = 1'b0;
  initial op_done = 1'b0;
  // speed is reached spin_dly cycles after the request, lost when not requested
  always @(posedge clock) begin
    spin_cnt <= spin_up_req ? spin_cnt + 16'h0001 : 16'h0000;
    spin_ready <= spin_up_req && (spin_cnt >= spin_dly);
  end
  // finish done_dly cycles after start; zero means always finished
  always @(posedge clock) begin
    if (op_start) begin
      run <= 1'b1;
      done_cnt <= 16'h0000;
    end else if (run) begin
      done_cnt <= done_cnt + 16'h0001;
    end
    op_done <= (done_dly == 16'h0000) || (run && (done_cnt == done_dly));
  end
endmodule : sdc_far_model
`default_nettype wire

// *** sata_drive_command_deviation_logic_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sdc_map.svh"
module sata_drive_command_deviation_logic_bench;
  localparam int MS = 10; // cycles per ms in this run
  logic clock, rst_b, ce, avs_read, avs_write, link_reset_req; // design inputs
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic avs_waitrequest, spin_ready, op_done, op_start, spin_up_req, init_signal, host_intrq, irq;
  logic [15:0] spin_dly, done_dly, lim; // partner timing and a drawn limit
  logic [7:0] code, opc; // command being issued, code latched by the design
  logic [31:0] rd; // last read word
  logic [2:0] modes [3] = '{3'h0, 3'h1, 3'h4}; // idle, idle with ext power, standby
  int n_errors = 0;
  int cmp_count = 0;
  int seed, i, n;
  time t0, t_por; // start of a link reset, release of power-on reset
  sdc_cmd_core #(.MS_TICKS(MS)) i_dut (.clock(clock), .rst_b(rst_b), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link_reset_req(link_reset_req),
    .spin_ready(spin_ready), .op_done(op_done), .op_start(op_start), .op_code(opc),
    .spin_up_req(spin_up_req), .init_signal(init_signal), .host_intrq(host_intrq), .irq(irq));
  sdc_far_model i_far (.clock(clock), .spin_up_req(spin_up_req), .op_start(op_start),
    .spin_dly(spin_dly), .done_dly(done_dly), .spin_ready(spin_ready), .op_done(op_done));
  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // compare one value and count it
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // avalon write, held until waitrequest is seen low
  task bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : bus_wr
  // avalon read, data taken at the edge that ends the wait
  task bus_rd(input logic [7:0] a);
    @(posedge clock);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
  endtask : bus_rd
  // count cycles until the interrupt line rises
  task wait_irq;
    n = 0;
    while (irq !== 1'b1) begin
      @(posedge clock);
      n++;
    end
  endtask : wait_irq
  // wait for the end of a command, check and clear its events
  task close_cmd(input logic [31:0] exp);
    wait_irq;
    bus_rd(`SDC_OFF_IRQ_STAT);
    chk("irq status", exp, rd);
    bus_wr(`SDC_OFF_IRQ_STAT, 32'h0000000F);
  endtask : close_cmd
  // answer of a power query for a control setting
  function logic [7:0] pm_exp(input logic [2:0] c);
    pm_exp = c[2] ? `SDC_PM_STBY : (c[0] ? `SDC_PM_IDLE_STD : `SDC_PM_IDLE_ALL);
  endfunction : pm_exp
  // events of a command issued with a recovery limit
  function logic [31:0] erc_exp(input logic [15:0] l);
    erc_exp = (l < `SDC_ERC_MIN_MS) ? 32'h00000002 : 32'h00000001;
  endfunction : erc_exp
  // link reset pulse and cycles until the answer
  task link_rst;
    t0 = $time;
    link_reset_req <= 1'b1;
    while (init_signal !== 1'b1) @(posedge clock);
    link_reset_req <= 1'b0;
    n = int'(($time - t0) / `SDC_CLK_PERIOD_NS);
  endtask : link_rst
  task report_and_stop;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // watchdog
  initial begin
    repeat (40000) @(posedge clock);
    n_errors++;
    report_and_stop;
  end
  // main sequence
  initial begin
    seed = 32'hCDA899D3;
    {rst_b, ce, avs_read, avs_write, link_reset_req} = 5'b01000;
    avs_address = 8'h00;
    avs_writedata = 32'h00000000;
    spin_dly = 16'h0005;
    done_dly = 16'h0005;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    t_por = $time;
    // power-on defaults and an unmapped word
    bus_rd(`SDC_OFF_CAUSE);
    chk("cause", {30'h0, `SDC_CAUSE_POR}, rd);
    bus_rd(`SDC_OFF_IRQ_MASK);
    chk("mask", 32'h00000000, rd);
    bus_rd(8'h3C);
    chk("unmapped", 32'h00000000, rd);
    bus_wr(`SDC_OFF_IRQ_MASK, 32'h0000000F);
    bus_wr(`SDC_OFF_TLIM, 32'h0000FFFF);
    // link reset inside the quiet interval, then a prompt one
    link_rst;
    n = int'(($time - t_por) / `SDC_CLK_PERIOD_NS) - `SDC_POR_QUIET_MS * MS; // past quiet end
    chk("late answer", 32'h1, 32'(n >= 0 && n <= 10));
    bus_rd(`SDC_OFF_CAUSE);
    chk("cause", {30'h0, `SDC_CAUSE_LINK}, rd);
    close_cmd(32'h00000004);
    link_rst;
    chk("prompt answer", 32'h1, 32'(n <= 10 * MS));
    close_cmd(32'h00000004);
    // command write clears the high byte select
    bus_wr(`SDC_OFF_CTRL, 32'h00000000);
    bus_wr(`SDC_OFF_DEVCTL, 32'h00000080);
    bus_rd(`SDC_OFF_DEVCTL);
    chk("devctl", 32'h00000088, rd);
    bus_wr(`SDC_OFF_CMD, {24'h0, `SDC_CMD_CHK_PWR});
    bus_rd(`SDC_OFF_DEVCTL);
    chk("devctl", 32'h00000008, rd);
    close_cmd(32'h00000001);
    // power query in every mode
    for (i = 0; i < 3; i++) begin
      bus_wr(`SDC_OFF_CTRL, {29'h0, modes[i]});
      bus_wr(`SDC_OFF_CMD, {24'h0, `SDC_CMD_CHK_PWR});
      bus_rd(`SDC_OFF_RESULT);
      chk("power answer", {24'h0, pm_exp(modes[i])}, rd);
      close_cmd(32'h00000001);
    end
    // both downloads refused while locked
    bus_wr(`SDC_OFF_CTRL, 32'h00000002);
    for (i = 0; i < 2; i++) begin
      bus_wr(`SDC_OFF_CMD, {24'h0, (i == 0) ? `SDC_CMD_DL : `SDC_CMD_DL_DMA});
      bus_rd(`SDC_OFF_RESULT);
      chk("abort flag", 32'h1, {31'h0, rd[`SDC_ER_ABRT + 8]});
      close_cmd(32'h00000002);
    end
    // unlocked download runs; status reads and interrupt masking
    bus_wr(`SDC_OFF_CTRL, 32'h00000000);
    bus_wr(`SDC_OFF_CMD, {24'h0, `SDC_CMD_DL});
    wait_irq;
    chk("host intrq", 32'h1, {31'h0, host_intrq});
    bus_rd(`SDC_OFF_ALTSTAT);
    chk("alt status", 32'h00000050, rd);
    @(posedge clock);
    chk("host intrq", 32'h1, {31'h0, host_intrq});
    bus_rd(`SDC_OFF_STATUS);
    chk("status", 32'h00000050, rd);
    @(posedge clock);
    chk("host intrq", 32'h0, {31'h0, host_intrq});
    bus_wr(`SDC_OFF_IRQ_MASK, 32'h00000000);
    @(posedge clock);
    chk("irq masked", 32'h0, {31'h0, irq});
    bus_wr(`SDC_OFF_IRQ_MASK, 32'h0000000F);
    close_cmd(32'h00000001);
    @(posedge clock);
    chk("irq cleared", 32'h0, {31'h0, irq});
    // recovery limits around the minimum, then drawn below it
    for (i = 0; i < 6; i++) begin
      lim = (i == 0) ? 16'd6499 : (i == 1) ? 16'd6500 : 16'({$random(seed)} % 6500);
      code = {2'b00, 6'($random(seed))};
      bus_wr(`SDC_OFF_TLIM, {15'h0, 1'b1, lim});
      bus_wr(`SDC_OFF_CMD, {24'h0, code});
      close_cmd(erc_exp(lim));
      chk("op code", {24'h0, code}, {24'h0, opc});
    end
    // streaming limit below the floor times out at the floor
    done_dly <= 16'hFFFF;
    for (i = 0; i < 2; i++) begin
      bus_wr(`SDC_OFF_TLIM, 32'd10);
      bus_wr(`SDC_OFF_CMD, {24'h0, (i == 0) ? `SDC_CMD_RD_STRM : `SDC_CMD_WR_STRM});
      wait_irq;
      chk("floor", 32'h1, 32'(n >= `SDC_COMPLETION_LIMIT_FLOOR_MS * MS - 10 && n <= 520));
      close_cmd(32'h0000000A);
    end
    // standby: completion waits for the spindle, the first time past an expired limit
    done_dly <= 16'h0000;
    for (i = 0; i < 2; i++) begin
      spin_dly <= (i == 0) ? 16'd800 : 16'd300;
      bus_wr(`SDC_OFF_CTRL, 32'h00000004);
      bus_wr(`SDC_OFF_TLIM, (i == 0) ? 32'd50 : 32'h00011964);
      bus_wr(`SDC_OFF_CMD, {24'h0, (i == 0) ? `SDC_CMD_RD_STRM : 8'h20});
      wait_irq;
      chk("spin wait", 32'h1, 32'(n >= ((i == 0) ? 800 : 300)));
      close_cmd(32'h00000001);
    end
    // soft reset held for 5 us
    bus_wr(`SDC_OFF_DEVCTL, 32'h00000004);
    bus_rd(`SDC_OFF_STATUS);
    chk("reset status", 32'h00000090, rd);
    repeat (500) @(posedge clock);
    bus_wr(`SDC_OFF_DEVCTL, 32'h00000000);
    bus_rd(`SDC_OFF_STATUS);
    chk("status", 32'h00000050, rd);
    // clock enable low freezes the bus handshake and the command
    @(posedge clock);
    ce <= 1'b0;
    avs_address <= `SDC_OFF_CMD;
    avs_writedata <= {24'h0, `SDC_CMD_CHK_PWR};
    avs_write <= 1'b1;
    repeat (10) @(posedge clock);
    chk("frozen wait", 32'h1, {31'h0, avs_waitrequest});
    chk("frozen irq", 32'h0, {31'h0, irq});
    ce <= 1'b1;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    close_cmd(32'h00000001);
    report_and_stop;
  end
endmodule : sata_drive_command_deviation_logic_bench
`default_nettype wire
